// *** hdl/asr_conv_ctrl.sv ***
`timescale 1ns/1ps

module asr_conv_ctrl #(
  parameter int RES_W      = asr_pkg::RES_W,
  parameter int FIFO_DEPTH = asr_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clk,            // System clock, 200 MHz.
  input  wire logic             i_nrst,           // Asynchronous reset, active low.
  input  wire logic             i_ce,             // Clock enable; all state holds while low.
  input  wire logic             i_conv_start_n,   // Conversion start pin, asynchronous.
  input  wire logic             i_sclk,           // Host serial clock pin, asynchronous.
  input  wire logic             i_bipolar,        // Static range select: high for bipolar.
  input  wire logic [RES_W-1:0] i_sar_code,       // Offset-binary code from the SAR core.
  output logic                  o_busy,           // Conversion in progress, active high.
  output logic                  o_hold,           // Track/hold in hold, active high.
  output logic                  o_sleep,          // Analog section powered down.
  output logic                  o_serial_data_out,          // Serial data output value.
  output logic                  o_serial_data_out_oe,       // Serial data output enable, high drives.
  output logic                  o_result_lost     // Sticky: a conversion ended with the result queue full.
);

  localparam int FRAME_BITS = asr_pkg::FRAME_BITS;
  localparam int AW         = $clog2(FIFO_DEPTH);

  // All state of the block except the result queue, registered as one word.
  typedef struct packed {
    logic                           cs_s1;      // Start pin, first sync stage.
    logic                           cs_s2;      // Start pin, second sync stage.
    logic                           cs_s3;      // Start pin, previous synced value.
    logic                           sck_s1;     // Serial clock, first sync stage.
    logic                           sck_s2;     // Serial clock, second sync stage.
    logic                           sck_s3;     // Serial clock, previous synced value.
    asr_pkg::asr_state_t            state;      // Converter sequencing state.
    logic [asr_pkg::CNT_W-1:0]      cnt;        // Wake or conversion timer.
    logic                           busy;
    logic                           hold;
    logic                           sleep;
    logic [RES_W-1:0]               out_word;   // Output register, last loaded result.
    logic [FRAME_BITS-1:0]          shreg;      // Output shift register.
    logic [asr_pkg::BCNT_W-1:0]     bit_cnt;    // Falling edges seen in this frame.
    logic                           in_frame;   // A read frame is running.
    logic                           done;       // Sixteen falling edges have been seen.
    logic                           keep;       // Overrun: output stays driven.
    logic                           oe;
    logic                           lost;       // Sticky overflow marker.
  } asr_regs_t;

  asr_regs_t        r_reg;
  asr_regs_t        r_next;
  logic             cs_rise;
  logic             cs_fall;
  logic             sck_rise;
  logic             sck_fall;
  logic             push;
  logic             pop;
  logic             fifo_ready;
  logic             fifo_valid;
  logic [RES_W-1:0] fifo_data;
  logic [RES_W-1:0] coded;

  // Edge detection looks only at the second and third stages, never the first.
  assign cs_rise  = r_reg.cs_s2 && !r_reg.cs_s3;
  assign cs_fall  = !r_reg.cs_s2 && r_reg.cs_s3;
  assign sck_rise = r_reg.sck_s2 && !r_reg.sck_s3;
  assign sck_fall = !r_reg.sck_s2 && r_reg.sck_s3;

  // result coding select
  // The SAR core yields offset binary; flipping its top bit gives two's complement.
  assign coded = i_bipolar ?
                 {~i_sar_code[asr_pkg::MSB_POS], i_sar_code[asr_pkg::MSB_POS-1:0]} :
                 i_sar_code;

  // Results queue here so a slow reader never blocks the converter at once.
  // A full queue stalls the end of conversion, keeping busy high until room opens.
  asr_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (AW)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_valid (push),
    .o_ready (fifo_ready),
    .i_data  (coded),
    .o_valid (fifo_valid),
    .i_ready (pop),
    .o_data  (fifo_data)
  );

  // Next-state logic for the synchronisers, the converter sequencer and the readout.
  always_comb begin
    r_next = r_reg;
    push   = 1'b0;
    pop    = 1'b0;
    if (i_ce) begin
      r_next.cs_s1  = i_conv_start_n;
      r_next.cs_s2  = r_reg.cs_s1;
      r_next.cs_s3  = r_reg.cs_s2;
      r_next.sck_s1 = i_sclk;
      r_next.sck_s2 = r_reg.sck_s1;
      r_next.sck_s3 = r_reg.sck_s2;

      // Readout runs on host clock edges and the start fall only, so pauses between bytes
      // simply leave the shifter where it stands.
      // pauses are harmless
      if (cs_fall && !r_reg.sck_s2) begin
        r_next.bit_cnt  = '0;
        r_next.shreg    = '0;
        r_next.in_frame = 1'b0;
        r_next.done     = 1'b0;
        r_next.keep     = 1'b0;
        r_next.oe       = 1'b0;
      end else if (sck_rise && !r_reg.in_frame) begin
        r_next.shreg    = {{asr_pkg::LEAD_ZEROS{1'b0}}, r_reg.out_word};
        r_next.in_frame = 1'b1;
        r_next.oe       = 1'b1;
        if (r_reg.done) begin
          r_next.keep = 1'b1;
        end
      end else if (sck_fall && r_reg.in_frame) begin
        if (r_reg.bit_cnt == asr_pkg::LAST_FALL) begin
          r_next.bit_cnt  = '0;
          r_next.in_frame = 1'b0;
          r_next.done     = 1'b1;
          r_next.oe       = r_reg.keep;
        end else begin
          r_next.bit_cnt = r_reg.bit_cnt + asr_pkg::BCNT_ONE;
          r_next.shreg   = {r_reg.shreg[FRAME_BITS-2:0], 1'b0};
        end
      end

      // The output register is refreshed only between frames, so a read in
      // progress always returns one consistent result.
      // new result to output register
      if (fifo_valid && !r_reg.in_frame && !sck_rise) begin
        pop             = 1'b1;
        r_next.out_word = fifo_data;
      end

      // Converter sequencer.
      case (r_reg.state)
        asr_pkg::ST_IDLE: begin
          r_next.sleep = 1'b0;
          if (cs_fall) begin
            // late fall holds, 4.5 us conversion
            r_next.hold  = 1'b1;
            r_next.busy  = 1'b1;
            r_next.cnt   = asr_pkg::CONV_HR_CYC - asr_pkg::CNT_ONE;
            r_next.state = asr_pkg::ST_CONV;
          end
        end
        asr_pkg::ST_CONV: begin
          if (r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - asr_pkg::CNT_ONE;
          end else if (fifo_ready) begin
            push        = 1'b1;
            r_next.busy = 1'b0;
            r_next.hold = 1'b0;
            // start level picks sleep or stay awake
            if (r_reg.cs_s2) begin
              r_next.state = asr_pkg::ST_IDLE;
            end else begin
              r_next.sleep = 1'b1;
              r_next.state = asr_pkg::ST_SLEEP;
            end
          end else begin
            r_next.lost = 1'b1;
          end
        end
        asr_pkg::ST_SLEEP: begin
          if (cs_rise) begin
            r_next.sleep = 1'b0;
            r_next.cnt   = asr_pkg::WAKE_CYC - asr_pkg::CNT_ONE;
            r_next.state = asr_pkg::ST_WAKE;
          end
        end
        asr_pkg::ST_WAKE: begin
          if (r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - asr_pkg::CNT_ONE;
          end else if (!r_reg.cs_s2) begin
            // hold at end of wake time
            r_next.hold  = 1'b1;
            r_next.busy  = 1'b1;
            r_next.cnt   = asr_pkg::CONV_WAKE_CYC - asr_pkg::CNT_ONE;
            r_next.state = asr_pkg::ST_CONV;
          end else begin
            // Pulse outlasts the wake time, so the falling edge will hold.
            r_next.state = asr_pkg::ST_IDLE;
          end
        end
        default: begin
          r_next.state = asr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // State register. Every field resets to a constant.
  // released output, zero count at reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg       <= '0;
      r_reg.state <= asr_pkg::ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // All outputs come straight from flip-flops.
  assign o_busy        = r_reg.busy;
  assign o_hold        = r_reg.hold;
  assign o_sleep       = r_reg.sleep;
  assign o_serial_data_out       = r_reg.shreg[FRAME_BITS-1];
  assign o_serial_data_out_oe    = r_reg.oe;
  assign o_result_lost = r_reg.lost;

endmodule

// *** hdl/asr_pkg.sv ***
package asr_pkg;

  // Clock rate of the block, used to turn times into cycle counts.
  localparam int CLK_MHZ = 200;

  // Times as specified, in nanoseconds.
  localparam int T_WAKE_NS      = 6000;   // Wake-up time from the rising start edge.
  localparam int T_CONV_WAKE_NS = 4000;   // Conversion after a wake-time hold.
  localparam int T_CONV_HR_NS   = 4500;   // Conversion after a hold on the falling edge.
  localparam int T_SETTLE_NS    = 500;    // Quiet time the host leaves before the next sample.

  // Counter width and derived cycle counts.
  localparam int CNT_W = 11;
  // The wake-up time is a least time, so it rounds up.
  localparam logic [CNT_W-1:0] WAKE_CYC =
    CNT_W'((T_WAKE_NS * CLK_MHZ + 999) / 1000);
  // Conversion times are longest times, so they round down.
  localparam logic [CNT_W-1:0] CONV_WAKE_CYC = CNT_W'((T_CONV_WAKE_NS * CLK_MHZ) / 1000);
  localparam logic [CNT_W-1:0] CONV_HR_CYC   = CNT_W'((T_CONV_HR_NS * CLK_MHZ) / 1000);
  localparam logic [CNT_W-1:0] CNT_ONE       = CNT_W'(1);

  // Result and frame layout.
  localparam int RES_W      = 14;
  localparam int FRAME_BITS = 16;
  localparam int LEAD_ZEROS = FRAME_BITS - RES_W;
  localparam int BCNT_W     = 5;
  localparam logic [BCNT_W-1:0] LAST_FALL = BCNT_W'(FRAME_BITS - 1);
  localparam logic [BCNT_W-1:0] BCNT_ONE  = BCNT_W'(1);
  localparam int MSB_POS    = RES_W - 1;   // Position of msb_bit in the result.
  localparam int FIFO_DEPTH = 8;

  // Converter sequencing states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,   // Awake, tracking, waiting for a falling start edge.
    ST_CONV  = 4'h2,   // Sample held, conversion running, busy high.
    ST_SLEEP = 4'h4,   // Powered down after a conversion.
    ST_WAKE  = 4'h8    // Waking up after a rising start edge.
  } asr_state_t;

endpackage

// *** hdl/asr_fifo.sv ***
`timescale 1ns/1ps

// Small result queue between the converter and the output register.
module asr_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic         i_clk,    // System clock.
  input  wire logic         i_nrst,   // Asynchronous reset, active low.
  input  wire logic         i_ce,     // Clock enable; all state holds while low.
  input  wire logic         i_valid,  // Write side offers a word.
  output logic              o_ready,  // Write side may push (not full).
  input  wire logic [W-1:0] i_data,   // Word to write.
  output logic              o_valid,  // Read side has a word (not empty).
  input  wire logic         i_ready,  // Read side takes the word.
  output logic [W-1:0]      o_data    // Oldest word, straight from storage.
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             level;
  } asr_fifo_regs_t;

  localparam logic [AW:0]   LVL_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0]   LVL_ONE  = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  asr_fifo_regs_t r_reg;
  asr_fifo_regs_t r_next;
  logic           push;
  logic           pop;

  // Flags are taken from the level count so full and empty never disagree.
  assign o_ready = (r_reg.level != LVL_FULL);
  assign o_valid = (r_reg.level != '0);
  assign o_data  = r_reg.mem[r_reg.rd];
  assign push    = i_ce && i_valid && o_ready;
  assign pop     = i_ce && i_ready && o_valid;

  // Pointer and level update; pointers wrap so any depth works.
  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wr] = i_data;
      r_next.wr = (r_reg.wr == PTR_LAST) ? '0 : r_reg.wr + PTR_ONE;
    end
    if (pop) begin
      r_next.rd = (r_reg.rd == PTR_LAST) ? '0 : r_reg.rd + PTR_ONE;
    end
    if (push && !pop) begin
      r_next.level = r_reg.level + LVL_ONE;
    end else if (pop && !push) begin
      r_next.level = r_reg.level - LVL_ONE;
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

// *** testbench/asr_conv_ctrl_sva.sv ***
`timescale 1ns/1ps
// Watches the converter pins for conversion timing and readout framing.
module asr_conv_ctrl_chk #(
  parameter int RES_W      = 14,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic             i_clk,           // System clock.
  input wire logic             i_nrst,          // Reset, active low.
  input wire logic             i_ce,            // Clock enable.
  input wire logic             i_conv_start_n,  // Start pin.
  input wire logic             i_sclk,          // Host serial clock.
  input wire logic             i_bipolar,       // Range select.
  input wire logic [RES_W-1:0] i_sar_code,      // Core code.
  input wire logic             o_busy,          // Busy.
  input wire logic             o_hold,          // Hold.
  input wire logic             o_sleep,         // Sleep.
  input wire logic             o_serial_data_out,         // Serial data.
  input wire logic             o_serial_data_out_oe,      // Serial data enable.
  input wire logic             o_result_lost    // Lost result flag.
);
  typedef struct packed {
    logic [asr_pkg::CNT_W-1:0] busy_len;
  } asr_chk_state_t;
  asr_chk_state_t st_reg;
  asr_chk_state_t st_next;

  // Length of the running busy pulse, read on the cycle it ends.
  always_comb begin
    st_next = st_reg;
    st_next.busy_len = o_busy ? st_reg.busy_len + 1'b1 : '0;
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_hold_follows_busy: assert property (o_hold == o_busy)
    else $error("hold and busy differ");
  a_busy_rise_cause: assert property ($rose(o_busy) |-> !$past(i_conv_start_n, 3))
    else $error("busy rose without a low start pin");
  // A stalled result stretches busy, so only clean conversions are timed.
  a_conv_length: assert property ($fell(o_busy) && !o_result_lost |->
      st_reg.busy_len == asr_pkg::CONV_HR_CYC || st_reg.busy_len == asr_pkg::CONV_WAKE_CYC)
    else $error("busy pulse length wrong");
  a_mode_at_end: assert property ($fell(o_busy) |-> o_sleep == !$past(i_conv_start_n, 3))
    else $error("sleep choice at conversion end wrong");
  a_sleep_entry: assert property ($rose(o_sleep) |-> $fell(o_busy))
    else $error("sleep entered away from busy fall");
  a_wake_on_rise: assert property (o_sleep && $rose(i_conv_start_n) |-> ##[1:6] !o_sleep)
    else $error("rising start did not wake");
  a_first_zero: assert property ($rose(o_serial_data_out_oe) |-> !o_serial_data_out && $past(i_sclk, 2))
    else $error("frame start without clock rise or nonzero");
  a_bit_holds: assert property ($rose(i_sclk) && o_serial_data_out_oe |=> $stable(o_serial_data_out) [*6])
    else $error("data moved while clock high");
  a_release_low: assert property ($fell(o_serial_data_out_oe) |-> !i_sclk)
    else $error("data released while clock high");
endmodule

bind asr_conv_ctrl asr_conv_ctrl_chk #(.RES_W(RES_W), .FIFO_DEPTH(FIFO_DEPTH)) u_asr_conv_ctrl_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_conv_start_n(i_conv_start_n),
  .i_sclk(i_sclk), .i_bipolar(i_bipolar), .i_sar_code(i_sar_code), .o_busy(o_busy),
  .o_hold(o_hold), .o_sleep(o_sleep), .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe(o_serial_data_out_oe),
  .o_result_lost(o_result_lost));

// *** testbench/asr_host_model.sv ***
`timescale 1ns/1ps
// Host serial master: supplies every clock pulse and captures before each fall.
module asr_host_model (
  output logic      o_sclk,   // Serial clock to the device.
  input  wire logic i_serial_data_out,  // Device data value.
  input  wire logic i_oe      // Device drives data when high.
);
  logic last_bit;
  wire  line_level;

  // A released line shows the inverse of the last bit, so stale data never passes.
  always @(i_serial_data_out or i_oe) if (i_oe) last_bit = i_serial_data_out;
  assign line_level = i_oe ? i_serial_data_out : ~last_bit;

  initial o_sclk = 1'b0;

  task automatic read_bits(input int n, input int gap_ns, output logic [31:0] w);
    w = '0;
    #1.3;
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'b1;
      #40;
      w = {w[30:0], line_level};
      o_sclk = 1'b0;
      #40;
      if (i % 8 == 7) #(gap_ns);
    end
  endtask
endmodule

// *** testbench/asr_conv_ctrl_test.sv ***
`timescale 1ns/1ps
// Drives conversions and reads, scoring every frame against the bench's own codes.
module asr_conv_ctrl_test;
  logic        i_clk;
  logic        i_nrst;
  logic        i_ce;
  logic        i_conv_start_n;
  logic        i_bipolar;
  logic [13:0] i_sar_code;
  logic        o_busy, o_hold, o_sleep, o_serial_data_out, o_serial_data_out_oe, o_result_lost;
  wire         sclk;
  int          miscompares;
  int          checks;
  int          cycles;
  int          t;
  logic [31:0] w;
  logic [13:0] c;
  logic        b;
  logic [13:0] codes[10];

  asr_conv_ctrl u_asr_conv_ctrl (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_conv_start_n(i_conv_start_n), .i_sclk(sclk), .i_bipolar(i_bipolar),
    .i_sar_code(i_sar_code), .o_busy(o_busy), .o_hold(o_hold), .o_sleep(o_sleep),
    .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe(o_serial_data_out_oe), .o_result_lost(o_result_lost));
  asr_host_model u_asr_host_model (.o_sclk(sclk), .i_serial_data_out(o_serial_data_out), .i_oe(o_serial_data_out_oe));

  // System clock, 5 ns period.
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Frame as the host sees it: two zeros, then the coded result.
  function automatic logic [15:0] exp_word(input logic [13:0] code, input logic bip);
    return {2'b00, code[13] ^ bip, code[12:0]};
  endfunction

  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_time(input string name, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Start pin high for hi cycles, then low; n counts cycles from the fall to busy low.
  task automatic convert(input logic [13:0] code, input logic bip, input int hi,
                         input bit stay_low, output int n);
    bit seen;
    seen = 0;
    n = 0;
    @(posedge i_clk);
    i_sar_code <= code;
    i_bipolar <= bip;
    i_conv_start_n <= 1'b1;
    repeat (hi) @(posedge i_clk);
    i_conv_start_n <= 1'b0;
    while (!(seen && o_busy === 1'b0) && n < 2500) begin
      @(posedge i_clk);
      n++;
      if (n == 20 && !stay_low) i_conv_start_n <= 1'b1;
      if (o_busy === 1'b1) seen = 1;
    end
  endtask

  // read after busy falls, long quiet time before the next start
  task automatic read_check(input logic [15:0] exp, input int gap);
    u_asr_host_model.read_bits(16, gap, w);
    chk_val("frame", {16'h0, exp}, w);
    repeat (10) @(posedge i_clk);
    chk_val("enable after frame", 32'h0, o_serial_data_out_oe);
    repeat (200) @(posedge i_clk);
  endtask

  // Cuts a hang short; the whole run needs about 25000 cycles.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    i_nrst = 1'b0;
    i_ce = 1'b1;
    i_conv_start_n = 1'b1;
    i_bipolar = 1'b0;
    i_sar_code = 14'h0000;
    void'($urandom(32'hdb97024a));
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk_val("enable after reset", 32'h0, o_serial_data_out_oe);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      c = 14'($urandom());
      b = 1'($urandom());
      convert(c, b, 1, 0, t);
      chk_time("busy from start fall", 900, 912, t);
      chk_val("awake after high end", 32'h0, o_sleep);
      read_check(exp_word(c, b), $urandom_range(300));
    end
    $display("test high rate done");
    c = 14'($urandom());
    convert(c, 1'b0, 1, 1, t);
    chk_val("sleep after low end", 32'h1, o_sleep);
    read_check(exp_word(c, 1'b0), 40);
    c = 14'($urandom());
    convert(c, 1'b1, 100, 1, t);
    chk_time("wake conversion from rise", 2000, 2014, t + 100);
    read_check(exp_word(c, 1'b1), 0);
    c = 14'($urandom());
    convert(c, 1'b0, 1300, 0, t);
    chk_time("long pulse from fall", 900, 912, t);
    chk_val("awake after long pulse", 32'h0, o_sleep);
    read_check(exp_word(c, 1'b0), 0);
    $display("test sleep done");
    c = 14'($urandom());
    convert(c, 1'b1, 1, 0, t);
    u_asr_host_model.read_bits(20, 0, w);
    // The four extra pulses return the top four bits of the same frame again.
    chk_val("extra pulses", {12'h0, exp_word(c, 1'b1), 4'(exp_word(c, 1'b1) >> 12)}, w);
    repeat (10) @(posedge i_clk);
    chk_val("enable kept after extra", 32'h1, o_serial_data_out_oe);
    // The host leaves its settling time before the next start fall.
    // quiet before sample
    repeat (100) @(posedge i_clk);
    c = 14'($urandom());
    convert(c, 1'b1, 1, 0, t);
    chk_val("enable after start fall", 32'h0, o_serial_data_out_oe);
    read_check(exp_word(c, 1'b1), 0);
    $display("test overrun done");
    // A burst with no read between conversions: the output register takes each
    // new result one cycle after busy falls, so the queue never fills and the newest is read.
    b = 1'($urandom());
    for (int k = 0; k < 10; k++) begin
      codes[k] = 14'($urandom());
      convert(codes[k], b, 1, 0, t);
      chk_time("busy in burst", 900, 912, t);
    end
    chk_val("busy low after burst", 32'h0, o_busy);
    chk_val("no result lost", 32'h0, o_result_lost);
    read_check(exp_word(codes[9], b), $urandom_range(200));
    $display("test queue done");
    complete_run();
  end
endmodule
